// >>> rtl/mswled_pkg.sv
// Package: timing constants and the radio carrier type for the magnet switch, LED and radio timeout block.
// Assumes a single 50 MHz block clock.
package mswled_pkg;
  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // ---------------------------------------------------------------
  // Durations in milliseconds, counted in ticks
  // ---------------------------------------------------------------
  localparam int unsigned RADIO_WINDOW_MS = 3_600_000;
  localparam int unsigned HOLD_RESET_MS = 10_000;
  localparam int unsigned HOLD_FAST_MS = 3_000;
  localparam int unsigned LED_POWERUP_MS = 2_000;
  localparam int unsigned LED_TAP_MS = 200;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 100;
  localparam int unsigned SOLID_MS = 1_000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned TIME_W = 22;
  // ---------------------------------------------------------------
  // Carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic advertising;
    logic connect_allowed;
    logic access_allowed;
  } mswled_radio_t;
endpackage

// >>> rtl/mswled_debounce.sv
// Debouncer for the reed switch pin.
// Assumes a 1 ms tick pulse from the block timebase.
`timescale 1ns/100ps
`default_nettype none
module mswled_debounce #(
  parameter int unsigned DEB_TICKS = mswled_pkg::DEBOUNCE_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_raw,
  output logic o_level
);
  logic sync_a;
  logic sync_b;
  logic [7:0] cnt;
  wire differs = sync_b != o_level;
  wire settled = cnt >= 8'(DEB_TICKS - 1);

  // ---------------------------------------------------------------
  // Two-stage synchroniser, then accept only a level stable for the interval
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= 8'h00;
      o_level <= 1'b0;
    end
    else
    begin
      sync_a <= i_raw;
      sync_b <= sync_a;
      if (!differs)
        cnt <= 8'h00;
      else if (i_tick && settled)
      begin
        o_level <= sync_b;
        cnt <= 8'h00;
      end
      else if (i_tick)
        cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/mswled_ctrl.sv
// Top level: radio advertising window, switch tap and hold handling, LED patterns.
// Assumes battery insertion drives i_rst; i_switch_raw is an asynchronous pin.
`timescale 1ns/100ps
`default_nettype none
module mswled_ctrl #(
  parameter int unsigned TICK_CYCLES = mswled_pkg::TICK_CYCLES,
  parameter int unsigned RADIO_MS = mswled_pkg::RADIO_WINDOW_MS,
  parameter int unsigned HOLD_MS = mswled_pkg::HOLD_RESET_MS,
  parameter int unsigned FAST_MS = mswled_pkg::HOLD_FAST_MS,
  parameter int unsigned DEB_MS = mswled_pkg::DEBOUNCE_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_switch_raw,
  input wire logic i_connect_req,
  input wire logic i_connected,
  output var mswled_pkg::mswled_radio_t o_radio,
  output logic o_meas_start,
  output logic o_sensor_reset,
  output logic o_led
);
  typedef enum logic [2:0] {IDLE, HOLD, SOLID, RESET_OUT} mswled_state_t;
  localparam logic [mswled_pkg::TIME_W-1:0] T_ONE = 22'h000001;

  mswled_state_t state;
  mswled_state_t next_state;
  logic [31:0] pre;
  logic tick;
  logic sw;
  logic sw_q;
  logic [mswled_pkg::TIME_W-1:0] radio_left;
  logic [mswled_pkg::TIME_W-1:0] led_left;
  logic [mswled_pkg::TIME_W-1:0] hold_ms;
  logic [mswled_pkg::TIME_W-1:0] phase;
  logic blink;
  logic adv;

  function automatic logic [mswled_pkg::TIME_W-1:0] ms(input int unsigned v);
    return mswled_pkg::TIME_W'(v);
  endfunction

  // ---------------------------------------------------------------
  // Prescaled timebase: one tick per millisecond
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      pre <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= pre == 32'(TICK_CYCLES - 1);
      pre <= (pre == 32'(TICK_CYCLES - 1)) ? 32'h0 : pre + 32'h1;
    end
  end

  mswled_debounce #(
    .DEB_TICKS(DEB_MS)
  ) u_deb (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_raw(i_switch_raw),
    .o_level(sw)
  );

  // Edge and duration decode
  wire press = sw && !sw_q;
  wire release_ev = !sw && sw_q;
  wire held_long = hold_ms >= ms(HOLD_MS);
  wire tap_done = release_ev && state == HOLD;
  wire solid_done = led_left == '0;
  wire fast_zone = hold_ms >= ms(FAST_MS);
  wire [mswled_pkg::TIME_W-1:0] half = fast_zone ? ms(mswled_pkg::FAST_HALF_MS)
                                                 : ms(mswled_pkg::SLOW_HALF_MS);

  // ---------------------------------------------------------------
  // Hold state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      IDLE: if (press) next_state = HOLD;
      HOLD:
        if (!sw) next_state = IDLE;
        else if (held_long) next_state = SOLID;
      SOLID: if (solid_done) next_state = RESET_OUT;
      RESET_OUT: next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= IDLE;
      sw_q <= 1'b0;
      hold_ms <= '0;
      phase <= '0;
      blink <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sw_q <= sw;
      if (state != HOLD)
        hold_ms <= '0;
      else if (tick)
        hold_ms <= hold_ms + T_ONE;
      if (state != HOLD || !tick)
        phase <= (state != HOLD) ? '0 : phase;
      else if (phase + T_ONE >= half)
      begin
        phase <= '0;
        blink <= !blink;
      end
      else
        phase <= phase + T_ONE;
      if (state != HOLD)
        blink <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Radio window and LED on-time counters
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      radio_left <= ms(RADIO_MS);
      led_left <= ms(mswled_pkg::LED_POWERUP_MS);
    end
    else
    begin
      if (press)
        radio_left <= ms(RADIO_MS);
      else if (tick && radio_left != '0)
        radio_left <= radio_left - T_ONE;
      if (press)
        led_left <= ms(mswled_pkg::LED_TAP_MS);
      else if (state == HOLD && held_long)
        led_left <= ms(mswled_pkg::SOLID_MS);
      else if (tick && led_left != '0)
        led_left <= led_left - T_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign adv = radio_left != '0;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_radio <= '0;
      o_meas_start <= 1'b0;
      o_sensor_reset <= 1'b0;
      o_led <= 1'b0;
    end
    else
    begin
      o_radio.advertising <= adv;
      o_radio.connect_allowed <= adv && i_connect_req;
      o_radio.access_allowed <= i_connected && (adv || o_radio.access_allowed);
      o_meas_start <= tap_done && !held_long;
      o_sensor_reset <= state == RESET_OUT;
      case (state)
        HOLD: o_led <= (led_left != '0) || blink;
        SOLID: o_led <= 1'b1;
        default: o_led <= led_left != '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> dv/mswled_magnet_model.sv
// Magnet operator model: drives the reed switch pin with contact bounce.
// Assumes the bench calls its task just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module mswled_magnet_model (
  input wire logic i_ref_clk,
  output logic o_switch
);
  initial o_switch = 1'b0;
  // Bounce around the new level, settle, then keep it for cyc cycles
  // A cyc of at least one keeps two calls from driving the pin in one step
  task automatic drive(input logic lvl, input int cyc);
    repeat (3)
    begin
      o_switch = lvl;
      @(negedge i_ref_clk);
      o_switch = ~lvl;
      @(negedge i_ref_clk);
    end
    o_switch = lvl;
    repeat (cyc) @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/mswled_ctrl_sva.sv
// Checker: port-level properties of the switch, LED and radio controller.
// Assumes it is bound onto mswled_ctrl.
`timescale 1ns/100ps
`default_nettype none
module mswled_ctrl_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire mswled_pkg::mswled_radio_t o_radio,
  input wire logic o_meas_start,
  input wire logic o_sensor_reset,
  input wire logic o_led
);
  default clocking dcb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0)
    i_rst |=> o_radio == '0 && !o_led && !o_meas_start && !o_sensor_reset)
    else $error("outputs active in reset");
  a_adv_at_start: assert property ($fell(i_rst) |-> ##[0:2] o_radio.advertising)
    else $error("no advertising after reset");
  a_led_at_start: assert property ($fell(i_rst) |-> ##3 o_led [*8])
    else $error("no led after reset");
  a_conn_needs_adv: assert property (o_radio.connect_allowed |->
    o_radio.advertising || $past(o_radio.advertising)) else $error("connect without adv");
  a_access_rise_adv: assert property ($rose(o_radio.access_allowed) |->
    o_radio.advertising || $past(o_radio.advertising)) else $error("access without adv");
  a_meas_pulse_adv: assert property (o_meas_start |->
    o_radio.advertising ##1 !o_meas_start) else $error("bad measure pulse");
  a_sreset_after_solid: assert property (o_sensor_reset |->
    $past(o_led, 20) ##1 !o_sensor_reset) else $error("bad sensor reset pulse");
  a_led_min_on: assert property ($rose(o_led) |-> o_led [*8])
    else $error("led pulse too short");
endmodule
bind mswled_ctrl mswled_ctrl_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .o_radio(o_radio), .o_meas_start(o_meas_start), .o_sensor_reset(o_sensor_reset),
  .o_led(o_led));
`default_nettype wire

// >>> dv/mswled_ctrl_test.sv
// Testbench: reset, radio timeout, glitches, random taps, a long hold and a battery swap.
// Assumes shortened timing parameters and the magnet operator model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("ERROR %s expected %0h got %0h", nm, ex, got); \
    end \
  end
module mswled_ctrl_test;
  localparam int TK = 10;
  localparam int RADIO = 200;
  localparam int HOLD = 800;
  localparam int FAST = 600;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sw;
  logic req = 1'b0;
  logic con = 1'b0;
  mswled_pkg::mswled_radio_t radio;
  logic meas;
  logic srst;
  logic led;
  logic [15:0] lf = 16'hd2f8;
  int n_fail = 0;
  int cmp_count = 0;
  int meas_seen = 0;
  int srst_seen = 0;
  int acc_seen = 0;
  int held = 0;
  int k;
  mswled_magnet_model u_mag (.i_ref_clk(i_ref_clk), .o_switch(sw));
  mswled_ctrl #(
    .TICK_CYCLES(TK), .RADIO_MS(RADIO), .HOLD_MS(HOLD), .FAST_MS(FAST), .DEB_MS(2)
  ) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_switch_raw(sw), .i_connect_req(req),
    .i_connected(con), .o_radio(radio), .o_meas_start(meas), .o_sensor_reset(srst),
    .o_led(led));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Boot LED level expected a given number of ticks after release
  function automatic logic boot_led(input int t);
    return t < mswled_pkg::LED_POWERUP_MS;
  endfunction
  // LED level expected t ticks into a continuous hold: tap flash, slow, fast, solid, off
  // Fast blinking opens with a flip at the zone boundary
  function automatic logic hold_led(input int t);
    if (t < mswled_pkg::LED_TAP_MS)
      return 1'b1;
    if (t < FAST)
      return 1'((t / mswled_pkg::SLOW_HALF_MS) % 2);
    if (t < HOLD)
      return 1'((FAST / mswled_pkg::SLOW_HALF_MS + (t - FAST) / mswled_pkg::FAST_HALF_MS + 1) % 2);
    return t < HOLD + mswled_pkg::SOLID_MS;
  endfunction
  task automatic ticks(input int n);
    repeat (n * TK) @(negedge i_ref_clk);
  endtask
  // Keep the magnet on for n more ticks, then compare the LED with the hold pattern
  task automatic hold_for(input int n);
    u_mag.drive(1'b1, n * TK);
    held += n;
    `CHK("hold led", hold_led(held - 2), led)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // Random central traffic and pulse counters
  always @(negedge i_ref_clk)
  begin
    lf <= nxt(lf);
    req <= lf[0];
    con <= lf[1];
  end
  always @(posedge i_ref_clk)
  begin
    meas_seen <= meas_seen + int'(meas === 1'b1);
    srst_seen <= srst_seen + int'(srst === 1'b1);
    acc_seen <= acc_seen + int'(radio.access_allowed === 1'b1);
  end
  initial
  begin
    repeat (80000) @(posedge i_ref_clk); // About twice the scripted run
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    ticks(1);
    `CHK("advertising", 1'b1, radio.advertising)
    `CHK("connect allowed", req, radio.connect_allowed)
    `CHK("boot led", boot_led(1), led)
    ticks(RADIO - 11);
    `CHK("radio near end", 1'b1, radio.advertising)
    ticks(20);
    `CHK("radio timeout", 1'b0, radio.advertising)
    `CHK("access granted", 1'b1, acc_seen > 0)
    ticks(1691);
    `CHK("boot led late", boot_led(1901), led)
    ticks(200);
    `CHK("boot led off", boot_led(2101), led)
    `CHK("connect refused", 1'b0, radio.connect_allowed)
    `CHK("access refused", 1'b0, radio.access_allowed)
    u_mag.drive(1'b1, 1);
    u_mag.drive(1'b0, 50);
    `CHK("glitch ignored", 1'b0, radio.advertising)
    for (k = 0; k < 3; k++)
    begin
      u_mag.drive(1'b1, (5 + int'(lf[3:0])) * TK);
      `CHK("tap radio", 1'b1, radio.advertising)
      `CHK("tap led", 1'b1, led)
      u_mag.drive(1'b0, 10 * TK);
      `CHK("measure count", k + 1, meas_seen)
      `CHK("tap extends radio", 1'b1, radio.advertising)
    end
    ticks(250);
    `CHK("tap led off", 1'b0, led)
    `CHK("window over", 1'b0, radio.advertising)
    hold_for(100);
    hold_for(250);
    hold_for(200);
    hold_for(100);
    hold_for(100);
    hold_for(550);
    `CHK("no early reset", 0, srst_seen)
    hold_for(600);
    `CHK("hold reset", 1, srst_seen)
    u_mag.drive(1'b0, 20 * TK);
    `CHK("no measure on hold", 3, meas_seen)
    // Battery swap: a second reset in mid-run restarts the power-up behaviour
    i_rst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    `CHK("battery swap quiet", 1'b0, radio.advertising)
    i_rst = 1'b0;
    ticks(1);
    `CHK("restart advertising", 1'b1, radio.advertising)
    `CHK("restart led", boot_led(1), led)
    ticks(2);
    end_of_test();
  end
endmodule
`default_nettype wire
